// file: rtl/twdg_pkg.sv
package twdg_pkg;
    // Core clock rate
    localparam int CLK_MHZ = 20;
    // Window step sizes in microseconds
    localparam int FAST_STEP_US = 8;
    localparam int SLOW_STEP_US = 64;
    localparam int FAST_STEP_CYC = FAST_STEP_US * CLK_MHZ;
    localparam int SLOW_STEP_CYC = SLOW_STEP_US * CLK_MHZ;
    localparam int STEP_CNT_W = 11;
    // Timed reset state length
    localparam int TRESET_TIME_US = 1000;
    localparam int TRESET_CYC = TRESET_TIME_US * CLK_MHZ;
    localparam int TRESET_CNT_W = 15;
    // Window timer, counted in steps
    localparam int WIN_W = 8;
    localparam int TMR_W = WIN_W + 1;
    localparam logic [TMR_W-1:0] TMR_MAX = 9'h1FF;
    // Configuration reset values
    localparam logic [WIN_W-1:0] WIN_MIN_RST = 8'h10;
    localparam logic [WIN_W-1:0] WIN_DELTA_RST = 8'h20;
    localparam logic SLOW_RST = 1'b0;
    // Service codes
    localparam int CODE_W = 2;
    localparam logic [CODE_W-1:0] CODE_A = 2'h1;
    localparam logic [CODE_W-1:0] CODE_B = 2'h2;
    // One-hot watchdog states
    typedef enum logic [4:0] {
        ST_INITIAL = 5'h01,
        ST_RUN = 5'h02,
        ST_TEST = 5'h04,
        ST_TRESET = 5'h08,
        ST_OVERRIDE = 5'h10
    } twdg_state_t;
endpackage

// file: rtl/twdg_sync.sv
`timescale 1ns/1ps
module twdg_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q; // First stage, read only by second
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Next values
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    // Two flops against metastability
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;
endmodule

// file: rtl/twdg_step.sv
`timescale 1ns/1ps
module twdg_step (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slowMode,
    input wire logic restart,
    output logic stepPulse
);
    import twdg_pkg::*;

    logic [STEP_CNT_W-1:0] cnt_q; // Cycles inside current step
    logic [STEP_CNT_W-1:0] cnt_d;
    logic [STEP_CNT_W-1:0] lastCnt; // Terminal count for mode
    logic pulse_q;
    logic pulse_d;

    // Divider next state; restart aligns steps to the timer clear
    always_comb begin
        lastCnt = slowMode ? STEP_CNT_W'(SLOW_STEP_CYC - 1) : STEP_CNT_W'(FAST_STEP_CYC - 1);
        pulse_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (cnt_q >= lastCnt) begin
            cnt_d = '0;
            pulse_d = 1'b1;
        end else begin
            cnt_d = cnt_q + STEP_CNT_W'(1);
        end
    end

    // Register divider
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign stepPulse = pulse_q;
endmodule

// file: rtl/twdg_temporal_watchdog.sv
`timescale 1ns/1ps
module twdg_temporal_watchdog #(
    parameter int RESET_CYCLES = twdg_pkg::TRESET_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic stateMachineReset,
    input wire logic devInitState,
    input wire logic cfgWrite,
    input wire logic cfgSlowMode,
    input wire logic [twdg_pkg::WIN_W-1:0] cfgWinMin,
    input wire logic [twdg_pkg::WIN_W-1:0] cfgWinDelta,
    input wire logic serviceValid,
    input wire logic [twdg_pkg::CODE_W-1:0] serviceCode,
    input wire logic wdTestCommand,
    input wire logic watchdogDisablePin,
    output logic refreshAccepted,
    output logic windowError,
    output logic wdResetFlag,
    output logic wdTestIndicator,
    output logic armingLockoutLatch,
    output logic armEnable,
    output logic resetActive,
    output logic algoTestCmd,
    output logic [twdg_pkg::TMR_W-1:0] timerValue,
    output logic [4:0] stateOut
);
    import twdg_pkg::*;

    twdg_state_t state_q; // Watchdog state
    twdg_state_t state_d;
    logic [TMR_W-1:0] timer_q; // Window timer in steps
    logic [TMR_W-1:0] timer_d;
    logic [TRESET_CNT_W-1:0] rstCnt_q; // Timed reset counter
    logic [TRESET_CNT_W-1:0] rstCnt_d;
    logic haveA_q; // Code A seen this window
    logic haveA_d;
    logic haveB_q; // Code B seen this window
    logic haveB_d;
    logic slow_q; // Frozen timing config
    logic slow_d;
    logic [WIN_W-1:0] winMin_q;
    logic [WIN_W-1:0] winMin_d;
    logic [WIN_W-1:0] winDelta_q;
    logic [WIN_W-1:0] winDelta_d;
    logic wdr_q; // Sticky reset flag
    logic wdr_d;
    logic lock_q; // Sticky lockout latch
    logic lock_d;
    logic refresh_q;
    logic refresh_d;
    logic err_q;
    logic err_d;
    logic algo_q;
    logic algo_d;
    logic [TMR_W-1:0] winClose; // Last step inside window
    logic stepPulse;
    logic disableSync;
    logic codeOk; // Valid key seen this cycle
    logic earlyNow;
    logic lateNow;
    logic inWinNow;
    logic pairDone;
    logic supervised;
    logic errNow;

    // Slow and fast step generator, realigned at timer clear
    twdg_step stepGen (
        .clock(clock),
        .rst_n(rst_n),
        .slowMode(slow_q),
        .restart(timer_d == '0 && timer_q != '0),
        .stepPulse(stepPulse)
    );

    // Disable pin comes from outside the clock domain
    twdg_sync pinSync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn(watchdogDisablePin),
        .syncOut(disableSync)
    );

    // Window decode and service classification
    always_comb begin
        winClose = TMR_W'(winMin_q) + TMR_W'(winDelta_q);
        codeOk = serviceValid && (serviceCode == CODE_A || serviceCode == CODE_B);
        earlyNow = timer_q < TMR_W'(winMin_q);
        lateNow = timer_q > winClose;
        inWinNow = !earlyNow && !lateNow;
        pairDone = codeOk && ((serviceCode == CODE_A && haveB_q)
            || (serviceCode == CODE_B && haveA_q));
        supervised = state_q == ST_RUN || state_q == ST_TEST;
        // Wrong keys never count; timeout alone also errs
        errNow = supervised && ((codeOk && !inWinNow) || lateNow);
    end

    // Main state machine and its counters
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        rstCnt_d = '0;
        haveA_d = haveA_q;
        haveB_d = haveB_q;
        wdr_d = wdr_q;
        lock_d = lock_q;
        refresh_d = 1'b0;
        err_d = 1'b0;
        algo_d = wdTestCommand;
        case (state_q)
            ST_INITIAL: begin
                // No service needed; first valid code starts run
                timer_d = '0;
                if (wdTestCommand) begin
                    if (disableSync) begin
                        state_d = ST_OVERRIDE;
                    end
                end else if (codeOk) begin
                    state_d = ST_RUN;
                    haveA_d = serviceCode == CODE_A;
                    haveB_d = serviceCode == CODE_B;
                end
            end
            ST_RUN, ST_TEST: begin
                if (errNow) begin
                    // Error in test is expected, so no lockout
                    state_d = ST_TRESET;
                    err_d = 1'b1;
                    wdr_d = 1'b1;
                    if (state_q == ST_RUN) begin
                        lock_d = 1'b1;
                    end
                    haveA_d = 1'b0;
                    haveB_d = 1'b0;
                end else if (pairDone) begin
                    refresh_d = 1'b1;
                    timer_d = '0;
                    haveA_d = 1'b0;
                    haveB_d = 1'b0;
                end else begin
                    if (codeOk) begin
                        haveA_d = haveA_q || serviceCode == CODE_A;
                        haveB_d = haveB_q || serviceCode == CODE_B;
                    end
                    if (stepPulse && timer_q != TMR_MAX) begin
                        timer_d = timer_q + TMR_W'(1);
                    end
                    if (state_q == ST_RUN && wdTestCommand) begin
                        state_d = ST_TEST;
                    end
                end
            end
            ST_TRESET: begin
                // Fixed length, then back to run from zero
                timer_d = '0;
                if (rstCnt_q >= TRESET_CNT_W'(RESET_CYCLES - 1)) begin
                    state_d = ST_RUN;
                end else begin
                    rstCnt_d = rstCnt_q + TRESET_CNT_W'(1);
                end
            end
            ST_OVERRIDE: begin
                // Supervision off; test command ignored here
                timer_d = '0;
            end
            default: begin
                state_d = ST_INITIAL;
            end
        endcase
    end

    // Timing config, frozen once device leaves Init
    always_comb begin
        slow_d = slow_q;
        winMin_d = winMin_q;
        winDelta_d = winDelta_q;
        if (cfgWrite && devInitState) begin
            slow_d = cfgSlowMode;
            winMin_d = cfgWinMin;
            winDelta_d = cfgWinDelta;
        end
    end

    // Registers; state machine reset clears all but config
    always_ff @(posedge clock) begin
        if (!rst_n || stateMachineReset) begin
            state_q <= ST_INITIAL;
            timer_q <= '0;
            rstCnt_q <= '0;
            haveA_q <= 1'b0;
            haveB_q <= 1'b0;
            wdr_q <= 1'b0;
            lock_q <= 1'b0;
            refresh_q <= 1'b0;
            err_q <= 1'b0;
            algo_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            rstCnt_q <= rstCnt_d;
            haveA_q <= haveA_d;
            haveB_q <= haveB_d;
            wdr_q <= wdr_d;
            lock_q <= lock_d;
            refresh_q <= refresh_d;
            err_q <= err_d;
            algo_q <= algo_d;
        end
    end

    // Config only follows the power-on reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            slow_q <= SLOW_RST;
            winMin_q <= WIN_MIN_RST;
            winDelta_q <= WIN_DELTA_RST;
        end else begin
            slow_q <= slow_d;
            winMin_q <= winMin_d;
            winDelta_q <= winDelta_d;
        end
    end

    // Outputs; arming only in run or override and unlocked
    assign armEnable = (state_q == ST_RUN || state_q == ST_OVERRIDE) && !lock_q;
    assign wdTestIndicator = state_q == ST_TEST;
    assign resetActive = state_q == ST_TRESET;
    assign refreshAccepted = refresh_q;
    assign windowError = err_q;
    assign wdResetFlag = wdr_q;
    assign armingLockoutLatch = lock_q;
    assign algoTestCmd = algo_q;
    assign timerValue = timer_q;
    assign stateOut = state_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || stateMachineReset);

    property p_early;
        state_q == ST_RUN && codeOk && earlyNow |=> err_q && lock_q && wdr_q;
    endproperty
    a_early: assert property (p_early) else $error("early service missed");

    property p_initStay;
        state_q == ST_INITIAL && !serviceValid && !wdTestCommand |=> state_q == ST_INITIAL;
    endproperty
    a_initStay: assert property (p_initStay) else $error("left initial unprompted");

    property p_initArm;
        state_q == ST_INITIAL |-> !armEnable;
    endproperty
    a_initArm: assert property (p_initArm) else $error("arming in initial");

    property p_testNoLock;
        state_q == ST_TEST && !lock_q |=> !lock_q && !armEnable;
    endproperty
    a_testNoLock: assert property (p_testNoLock) else $error("lockout from test");

    property p_resetHold;
        state_q == ST_TRESET && rstCnt_q < TRESET_CNT_W'(RESET_CYCLES - 1)
            |=> state_q == ST_TRESET;
    endproperty
    a_resetHold: assert property (p_resetHold) else $error("timed reset too short");

    property p_resetExit;
        state_q == ST_TRESET && rstCnt_q == TRESET_CNT_W'(RESET_CYCLES - 1)
            |=> state_q == ST_RUN && timer_q == '0;
    endproperty
    a_resetExit: assert property (p_resetExit) else $error("timed reset exit wrong");

    property p_override;
        state_q == ST_OVERRIDE && !lock_q |-> armEnable ##1 state_q == ST_OVERRIDE;
    endproperty
    a_override: assert property (p_override) else $error("override not run-like");

    property p_refresh;
        refresh_q |-> $past(inWinNow) && timer_q == '0 && !err_q;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh outside window");

    property p_errFlag;
        err_q |-> wdr_q && state_q == ST_TRESET;
    endproperty
    a_errFlag: assert property (p_errFlag) else $error("error without flag");

    property p_lockArm;
        lock_q |-> !armEnable ##1 lock_q;
    endproperty
    a_lockArm: assert property (p_lockArm) else $error("lockout not sticky");

    property p_testCmd;
        state_q == ST_RUN && wdTestCommand && !errNow && !pairDone |=> wdTestIndicator;
    endproperty
    a_testCmd: assert property (p_testCmd) else $error("test entry failed");

    c_refresh: cover property (refresh_q);
    c_runError: cover property (err_q && lock_q);
    c_override: cover property (state_q == ST_OVERRIDE);
    c_testError: cover property (state_q == ST_TEST ##1 err_q && !lock_q);
endmodule

// file: test/twdg_host_model.sv
`timescale 1ns/1ps
module twdg_host_model (
    input wire logic clock,
    output logic serviceValid,
    output logic [twdg_pkg::CODE_W-1:0] serviceCode,
    output logic wdTestCommand
);
    import twdg_pkg::*;
    // Idle levels at time zero
    initial begin
        serviceValid = 1'b0;
        serviceCode = 2'h0;
        wdTestCommand = 1'b0;
    end
    // One service write; code lines flip once released, so a sent A or B leaves the other valid key standing while valid is low
    task automatic svc(input logic [CODE_W-1:0] code);
        @(negedge clock);
        serviceValid = 1'b1;
        serviceCode = code;
        @(negedge clock);
        serviceValid = 1'b0;
        serviceCode = ~code;
    endtask
    // One test command pulse
    task automatic test_cmd();
        @(negedge clock);
        wdTestCommand = 1'b1;
        @(negedge clock);
        wdTestCommand = 1'b0;
    endtask
endmodule

// file: test/twdg_temporal_watchdog_tb_top.sv
`timescale 1ns/1ps
module twdg_temporal_watchdog_tb_top;
    import twdg_pkg::*;
    localparam int RST_CYC = 50; // Short timed reset keeps the run brief
    localparam logic [WIN_W-1:0] MIN_V = 8'h02;
    localparam logic [WIN_W-1:0] DELTA_V = 8'h03;
    logic clock = 1'b0;
    logic rst_n, stateMachineReset, devInitState, cfgWrite, cfgSlowMode;
    logic [WIN_W-1:0] cfgWinMin, cfgWinDelta;
    logic serviceValid, wdTestCommand, watchdogDisablePin;
    logic [CODE_W-1:0] serviceCode;
    logic refreshAccepted, windowError, wdResetFlag, wdTestIndicator;
    logic armingLockoutLatch, armEnable, resetActive, algoTestCmd;
    logic [TMR_W-1:0] timerValue;
    logic [4:0] stateOut;
    int n_fail = 0;
    int checks_done = 0;
    int unsigned seedVal, tgt, ord;
    // Clock, 50 ns period
    always #25 clock = ~clock;
    twdg_temporal_watchdog #(.RESET_CYCLES(RST_CYC)) u_dut (
        .clock(clock), .rst_n(rst_n), .stateMachineReset(stateMachineReset),
        .devInitState(devInitState), .cfgWrite(cfgWrite), .cfgSlowMode(cfgSlowMode),
        .cfgWinMin(cfgWinMin), .cfgWinDelta(cfgWinDelta), .serviceValid(serviceValid),
        .serviceCode(serviceCode), .wdTestCommand(wdTestCommand),
        .watchdogDisablePin(watchdogDisablePin), .refreshAccepted(refreshAccepted),
        .windowError(windowError), .wdResetFlag(wdResetFlag),
        .wdTestIndicator(wdTestIndicator), .armingLockoutLatch(armingLockoutLatch),
        .armEnable(armEnable), .resetActive(resetActive), .algoTestCmd(algoTestCmd),
        .timerValue(timerValue), .stateOut(stateOut));
    twdg_host_model u_host (.clock(clock), .serviceValid(serviceValid),
        .serviceCode(serviceCode), .wdTestCommand(wdTestCommand));
    // Arming allowed only in run or override while unlocked
    function automatic logic exp_arm(input logic [4:0] st, input logic lock);
        return ((st == ST_RUN) || (st == ST_OVERRIDE)) && !lock;
    endfunction
    // Single comparison point
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
        end
    endtask
    // Let the answering edge land, then sample
    task automatic after();
        @(posedge clock);
        #1;
    endtask
    // Bounded wait for a given timer value
    task automatic wait_tmr(input int t);
        int n;
        n = 0;
        while (timerValue !== t[TMR_W-1:0] && n < 8000) begin
            after();
            n++;
        end
        chk(timerValue, t);
    endtask
    // Cycles from a zeroed timer to its first step
    task automatic meas(input int exp);
        int n;
        n = 0;
        while (timerValue === 9'h000 && n < 3000) begin
            after();
            n++;
        end
        chk((n >= exp - 2) && (n <= exp + 2), 1'b1);
    endtask
    // Error entry, timed reset, return to run; called in the error cycle
    task automatic err_chk(input logic fromRun);
        int n;
        chk(windowError, 1'b1);
        chk(wdResetFlag, 1'b1);
        chk({resetActive, stateOut}, {1'b1, ST_TRESET});
        chk(armingLockoutLatch, fromRun);
        chk(armEnable, 1'b0);
        repeat (RST_CYC - 2) @(posedge clock);
        #1;
        chk(stateOut, ST_TRESET);
        n = 0;
        while (stateOut !== ST_RUN && n < 8) begin
            after();
            n++;
        end
        // Timed reset lasts exactly RST_CYC edges, so two remain here
        chk(n, 2);
        chk(stateOut, ST_RUN);
        chk(timerValue, 9'h000);
    endtask
    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well above the expected run length
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        $display("mismatch at %0t: seen 0x0 expected 0x1 (timeout)", $time);
        wrap_up();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        stateMachineReset = 1'b0;
        devInitState = 1'b1;
        cfgWrite = 1'b0;
        cfgSlowMode = 1'b0;
        cfgWinMin = 8'h00;
        cfgWinDelta = 8'h00;
        watchdogDisablePin = 1'b0;
        seedVal = $urandom(79);
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        after();
        chk(stateOut, ST_INITIAL);
        chk(armEnable, 1'b0);
        chk({refreshAccepted, windowError, wdResetFlag, armingLockoutLatch}, 4'h0);
        // Accepted write, then a refused one outside Init
        @(negedge clock);
        cfgWrite = 1'b1;
        cfgWinMin = MIN_V;
        cfgWinDelta = DELTA_V;
        @(negedge clock);
        devInitState = 1'b0;
        cfgWinMin = 8'h00;
        @(negedge clock);
        cfgWrite = 1'b0;
        u_host.svc(2'h3);
        after();
        chk(stateOut, ST_INITIAL);
        u_host.test_cmd();
        chk(algoTestCmd, 1'b1);
        after();
        chk(stateOut, ST_INITIAL);
        $display("test init done");
        u_host.svc(CODE_A);
        after();
        chk(stateOut, ST_RUN);
        chk(armEnable, exp_arm(ST_RUN, 1'b0));
        wait_tmr(MIN_V);
        u_host.svc(CODE_B);
        // Refresh pulse stands one cycle only, so look before the next edge
        chk({refreshAccepted, timerValue}, {1'b1, 9'h000});
        meas(FAST_STEP_CYC);
        // Random refresh points and orders, wrong keys sent early
        for (int i = 0; i < 6; i++) begin
            tgt = MIN_V + ($urandom % DELTA_V);
            ord = $urandom % 2;
            u_host.svc(ord ? 2'h0 : 2'h3);
            chk(windowError, 1'b0);
            wait_tmr(tgt);
            u_host.svc(ord ? CODE_B : CODE_A);
            u_host.svc(ord ? CODE_A : CODE_B);
            chk({windowError, refreshAccepted, timerValue}, {2'b01, 9'h000});
        end
        $display("test refresh done");
        u_host.test_cmd();
        after();
        chk({wdTestIndicator, stateOut}, {1'b1, ST_TEST});
        chk(armEnable, 1'b0);
        // No service in test: timeout error, no lockout
        for (int n = 0; n < 1500 && windowError !== 1'b1; n++) after();
        err_chk(1'b0);
        u_host.svc(CODE_A);
        // Error pulse is still up in the cycle after the early code
        err_chk(1'b1);
        chk(armEnable, exp_arm(ST_RUN, 1'b1));
        $display("test error done");
        @(negedge clock);
        stateMachineReset = 1'b1;
        watchdogDisablePin = 1'b1;
        @(negedge clock);
        stateMachineReset = 1'b0;
        after();
        chk({stateOut, wdResetFlag, armingLockoutLatch, armEnable}, {ST_INITIAL, 3'h0});
        repeat (3) @(negedge clock);
        u_host.test_cmd();
        after();
        chk({stateOut, armEnable}, {ST_OVERRIDE, 1'b1});
        repeat (2000) @(posedge clock);
        #1;
        chk({stateOut, wdResetFlag}, {ST_OVERRIDE, 1'b0});
        $display("test override done");
        // Slow step after a full reset and reconfiguration
        @(negedge clock);
        rst_n = 1'b0;
        devInitState = 1'b1;
        cfgWrite = 1'b1;
        cfgSlowMode = 1'b1;
        cfgWinMin = MIN_V;
        @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        cfgWrite = 1'b0;
        u_host.svc(CODE_A);
        wait_tmr(MIN_V);
        u_host.svc(CODE_B);
        chk(refreshAccepted, 1'b1);
        meas(SLOW_STEP_CYC);
        $display("test slow done");
        wrap_up();
    end
endmodule
